// >>> osg_defs.svh
// Constants for the oscillator standby and output gating block
//----------------------------------------------------------------------
//----------------------------------------------------------------------
`ifndef OSG_DEFS_SVH
`define OSG_DEFS_SVH

`define OSG_CLK_PERIOD_NS   4
`define OSG_T_START_MS      75
`define OSG_T_START_MAX_MS  150
`define OSG_T_RESUME_US     2000
`define OSG_T_RESUME_MAX_US 3000
`define OSG_T_STDBY_MAX_US  20
// Cycle counts, typical figures, rounded down so the limits hold
`define OSG_START_CYC  ((`OSG_T_START_MS * 1000000) / `OSG_CLK_PERIOD_NS)
`define OSG_RESUME_CYC ((`OSG_T_RESUME_US * 1000) / `OSG_CLK_PERIOD_NS)
`define OSG_DIV_HALF   4'h4
`define OSG_CNT_W      25

`endif

// >>> osg_pkg.sv
// Types for the oscillator standby and output gating block
package osg_pkg;
   typedef enum logic [3:0] {
      OSG_POWERUP = 4'h1,
      OSG_ACTIVE  = 4'h2,
      OSG_STANDBY = 4'h4,
      OSG_RESUME  = 4'h8
   } osg_state_e;

   typedef struct packed {
      logic out_o;
      logic out_oe_n;
      logic out_pd;
   } osg_pin_s;
endpackage

// >>> osg_core.sv
// Mode control and glitch-free output gating of the oscillator
`timescale 1ns/1ns
`include "osg_defs.svh"
module osg_core
   import osg_pkg::*;
#(
   // Counts in internal clock cycles; a bench may shorten them
   parameter logic [`OSG_CNT_W-1:0] START_CYC  = `OSG_CNT_W'(`OSG_START_CYC),
   parameter logic [`OSG_CNT_W-1:0] RESUME_CYC = `OSG_CNT_W'(`OSG_RESUME_CYC)
) (
   // Clock and reset
   input  wire logic clk,
   input  wire logic arst_n,
   input  wire logic clk_en,
   // Host pin
   input  wire logic standby_select,
   // Output pin
   output osg_pin_s  pin,
   output logic      standby_active,
   output logic      powerdown_n
);

   //------------------------------------------------------------------
   // Synchronizer
   //------------------------------------------------------------------
   logic sel_s1_reg, sel_s2_reg;
   logic sel_s1_next, sel_s2_next;

   // Pin arrives asynchronous; first stage feeds only the second
   always_comb begin
      sel_s1_next = standby_select;
      sel_s2_next = sel_s1_reg;
   end

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         sel_s1_reg <= 1'b0;
         sel_s2_reg <= 1'b0;
      end else if (clk_en) begin
         sel_s1_reg <= sel_s1_next;
         sel_s2_reg <= sel_s2_next;
      end
   end

   //------------------------------------------------------------------
   // Fixed divider, the synthesized output clock
   //------------------------------------------------------------------
   logic [3:0] div_reg, div_next;
   logic       ck_reg, ck_next;
   logic       fall_edge;

   // Ratio is a constant; no port can retune it
   // The gate samples fall_edge, the last cycle of each high phase
   always_comb begin
      fall_edge = 1'b0;
      div_next  = div_reg + 4'h1;
      ck_next   = ck_reg;
      if (div_reg == `OSG_DIV_HALF - 4'h1) begin
         div_next  = 4'h0;
         ck_next   = ~ck_reg;
         fall_edge = ck_reg;
      end
   end

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         div_reg <= 4'h0;
         ck_reg  <= 1'b0;
      end else if (clk_en) begin
         div_reg <= div_next;
         ck_reg  <= ck_next;
      end
   end

   //------------------------------------------------------------------
   // Mode state machine
   //------------------------------------------------------------------
   osg_state_e                state_reg, state_next;
   logic [`OSG_CNT_W-1:0]     cnt_reg, cnt_next;
   logic                      gate_reg, gate_next;

   // The gate opens only after a timer completes, so the first pulse is already settled
   // A select pulse shorter than eight cycles, one divider period, may never be seen
   always_comb begin
      state_next = state_reg;
      cnt_next   = cnt_reg;
      gate_next  = gate_reg;
      case (state_reg)
         OSG_POWERUP: begin
            cnt_next = cnt_reg + 1'b1;
            if (cnt_reg >= START_CYC - 1'b1 && !sel_s2_reg) begin
               state_next = OSG_ACTIVE;
               cnt_next   = '0;
            end
         end
         OSG_ACTIVE: begin
            // Wait for the gate to close on a low phase first, so the
            // synthesizer is never powered down under a running pulse
            if (sel_s2_reg && !gate_reg) begin
               state_next = OSG_STANDBY;
            end
         end
         OSG_STANDBY: begin
            cnt_next = '0;
            if (!sel_s2_reg) begin
               state_next = OSG_RESUME;
            end
         end
         OSG_RESUME: begin
            cnt_next = cnt_reg + 1'b1;
            if (sel_s2_reg) begin
               state_next = OSG_STANDBY;
            end else if (cnt_reg >= RESUME_CYC - 1'b1) begin
               state_next = OSG_ACTIVE;
               cnt_next   = '0;
            end
         end
         default: state_next = OSG_POWERUP;
      endcase
      // Gate moves only at the falling phase edge: no runts
      if (fall_edge) begin
         gate_next = (state_reg == OSG_ACTIVE) && !sel_s2_reg;
      end
   end

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         state_reg <= OSG_POWERUP;
         cnt_reg   <= '0;
         gate_reg  <= 1'b0;
      end else if (clk_en) begin
         state_reg <= state_next;
         cnt_reg   <= cnt_next;
         gate_reg  <= gate_next;
      end
   end

   //------------------------------------------------------------------
   // Output pin
   //------------------------------------------------------------------
   logic out_reg, out_next;

   // Registered AND of gate and clock; both change on the same edge
   always_comb begin
      out_next = gate_next & ck_next;
   end

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         out_reg <= 1'b0;
      end else if (clk_en) begin
         out_reg <= out_next;
      end
   end

   // Driver off and weak pull-down on while disabled
   assign pin.out_o    = out_reg;
   assign pin.out_oe_n = ~gate_reg;
   assign pin.out_pd   = ~gate_reg;
   assign standby_active = (state_reg == OSG_STANDBY);
   assign powerdown_n    = (state_reg != OSG_STANDBY);

   //------------------------------------------------------------------
   // Assertions
   //------------------------------------------------------------------
   AST_NO_RUNT: assert property (@(posedge clk) disable iff (!arst_n)
      $rose(gate_reg) |-> !out_reg)
      else $error("Gate rose with output high");
   AST_GATE_LOW: assert property (@(posedge clk) disable iff (!arst_n)
      $changed(gate_reg) |-> !ck_reg)
      else $error("Gate changed while clock high");
   AST_STBY_OFF: assert property (@(posedge clk) disable iff (!arst_n)
      (state_reg == OSG_STANDBY) |-> (pin.out_oe_n && !pin.out_o))
      else $error("Output driven in standby");
   // Nine cycles of synced select cover a falling phase edge just
   // missed; far inside the standby time limit
   AST_OFF_FAST: assert property (@(posedge clk) disable iff (!arst_n)
      (clk_en throughout (sel_s2_reg [*8] ##1 sel_s2_reg)) |-> !gate_reg)
      else $error("Output not disabled promptly");
   AST_POWERUP_OFF: assert property (@(posedge clk) disable iff (!arst_n)
      (state_reg == OSG_POWERUP) |-> !gate_reg)
      else $error("Output enabled before startup ends");
   AST_RESUME_OFF: assert property (@(posedge clk) disable iff (!arst_n)
      (state_reg == OSG_RESUME) |-> !gate_reg)
      else $error("Output enabled during resume");
   // Entry waits for the gate, checked from the cycle it is closed
   AST_ENTER_STBY: assert property (@(posedge clk) disable iff (!arst_n)
      (state_reg == OSG_ACTIVE && sel_s2_reg && !gate_reg && clk_en)
      |=> state_reg == OSG_STANDBY)
      else $error("Standby not entered");
   AST_SYNC: assert property (@(posedge clk) disable iff (!arst_n)
      clk_en |=> sel_s2_reg == $past(sel_s1_reg))
      else $error("Synchronizer stage mismatch");
   AST_CLK_OUT: assert property (@(posedge clk) disable iff (!arst_n)
      (gate_reg && $past(gate_reg)) |-> out_reg == ck_reg)
      else $error("Output does not follow clock");

   // Mode and pin level checks
   AST_OFF_LOW: assert property (@(posedge clk) disable iff (!arst_n)
      pin.out_oe_n |-> (pin.out_pd && !pin.out_o))
      else $error("Released pin not pulled low");
   AST_OPEN_ACT: assert property (@(posedge clk) disable iff (!arst_n)
      $rose(gate_reg) |-> state_reg == OSG_ACTIVE)
      else $error("Gate opened outside active mode");
   AST_ABORT: assert property (@(posedge clk) disable iff (!arst_n)
      (state_reg == OSG_RESUME && sel_s2_reg && clk_en)
      |=> state_reg == OSG_STANDBY)
      else $error("Resume not abandoned on select high");
   AST_HOLD: assert property (@(posedge clk) disable iff (!arst_n)
      (state_reg == OSG_STANDBY && sel_s2_reg && clk_en)
      |=> state_reg == OSG_STANDBY)
      else $error("Standby left while select high");

   COV_ACTIVE: cover property (@(posedge clk) $rose(gate_reg));
   COV_STBY: cover property (@(posedge clk)
      state_reg == OSG_ACTIVE ##1 state_reg == OSG_STANDBY);
   COV_RESUME: cover property (@(posedge clk)
      state_reg == OSG_RESUME ##1 state_reg == OSG_ACTIVE);
   COV_ABORT: cover property (@(posedge clk)
      state_reg == OSG_RESUME ##1 state_reg == OSG_STANDBY);

endmodule

// >>> osg_host.sv
// Host model: drives standby_select and resolves the clock pin level
`timescale 1ns/1ns
module osg_host
   import osg_pkg::*;
(
   // Clock and reset
   input  wire logic clk,
   input  wire logic arst_n,
   // Bench command and device pin
   input  wire logic want,
   input  osg_pin_s  pin,
   output logic      standby_select,
   output logic      line
);
   logic last;
   // Select changes just after the edge; low at reset like a floating pin
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         standby_select <= 1'b0;
         last           <= 1'b0;
      end else begin
         standby_select <= want;
         last           <= line;
      end
   end
   // A released pin sits at the pull-down, or flips if nothing holds it
   always_comb line = !pin.out_oe_n ? pin.out_o : (pin.out_pd ? 1'b0 : ~last);
endmodule

// >>> osg_core_tb.sv
// Self-checking bench for the oscillator standby and output gating
`timescale 1ns/1ns
module osg_core_tb
   import osg_pkg::*;
;
   localparam int START  = 20;
   localparam int RESUME = 10;
   logic     clk, arst_n, want, standby_select, line;
   logic     standby_active, powerdown_n;
   osg_pin_s pin;
   int       mismatches, cmp_count, n;

   // Short counts keep the run brief; clk_en tied on
   osg_core #(.START_CYC(START), .RESUME_CYC(RESUME)) osg_core_i (
      .clk(clk), .arst_n(arst_n), .clk_en(1'b1),
      .standby_select(standby_select), .pin(pin),
      .standby_active(standby_active), .powerdown_n(powerdown_n));
   osg_host osg_host_i (.clk(clk), .arst_n(arst_n), .want(want),
      .pin(pin), .standby_select(standby_select), .line(line));

   task automatic chk(input string nm, input logic [31:0] e, g);
      cmp_count++;
      if (g !== e) begin
         mismatches++;
         $display("mismatch %s expected %0h seen %0h", nm, e, g);
      end
   endtask
   task automatic wait_oe(input logic v, input int lim, output int c);
      c = 0;
      while (pin.out_oe_n !== v && c < lim) begin
         @(negedge clk);
         c++;
      end
   endtask
   // Cycles the pin stays at v, once it gets there
   task automatic phase_len(input logic v, output int c);
      c = 0;
      for (int i = 0; i < 16 && line !== v; i++) @(negedge clk);
      while (line === v && c < 16) begin
         @(negedge clk);
         c++;
      end
   endtask
   task automatic t_powerup();
      logic early;
      early = 1'b0;
      repeat (START) begin
         @(negedge clk);
         if (pin.out_oe_n !== 1'b1 || line !== 1'b0) early = 1'b1;
      end
      chk("held_off", 0, early);
      wait_oe(1'b0, 16, n);
      chk("oe_n", 0, pin.out_oe_n);
      chk("pd", 0, pin.out_pd);
      phase_len(1'b1, n);
      chk("first_high", 4, n);
   endtask
   task automatic t_standby();
      @(posedge clk) want <= 1'b1;
      wait_oe(1'b1, 14, n);
      chk("oe_n", 1, pin.out_oe_n);
      chk("out_off", 0, pin.out_o);
      repeat (4) @(negedge clk);
      chk("pd", 1, pin.out_pd);
      chk("line", 0, line);
      chk("standby", 1, standby_active);
      chk("pwr_n", 0, powerdown_n);
   endtask
   task automatic t_resume();
      @(posedge clk) want <= 1'b0;
      wait_oe(1'b0, RESUME + 16, n);
      chk("resume", 1, n >= RESUME + 3 && n <= RESUME + 14);
      chk("awake", 0, standby_active);
      phase_len(1'b1, n);
      chk("first_high", 4, n);
      phase_len(1'b0, n);
      chk("low", 4, n);
   endtask
   // Select raised again in mid-resume sends the device back to standby
   // Starts from active, so standby is entered first
   task automatic t_abort();
      logic leak;
      leak = 1'b0;
      t_standby();
      @(posedge clk) want <= 1'b0;
      repeat (8) @(posedge clk);
      want <= 1'b1;
      repeat (10) begin
         @(negedge clk);
         if (pin.out_oe_n !== 1'b1) leak = 1'b1;
      end
      chk("back_stdby", 1, standby_active);
      chk("oe_n", 1, pin.out_oe_n);
      chk("abort_leak", 0, leak);
   endtask
   task automatic tally_and_finish();
      $display("checks %0d mismatches %0d", cmp_count, mismatches);
      if (mismatches == 0 && cmp_count > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask

   // Free-running 250 MHz clock
   initial begin
      clk = 1'b0;
      forever #2 clk = ~clk;
   end
   // Watchdog: the whole sequence needs under two hundred cycles
   initial begin
      #(4 * 1000);
      mismatches++;
      tally_and_finish();
   end
   // Main sequence
   initial begin
      arst_n = 1'b0;
      want = 1'b0;
      mismatches = 0;
      cmp_count = 0;
      @(negedge clk);
      chk("rst_oe_n", 1, pin.out_oe_n);
      @(posedge clk);
      @(posedge clk) arst_n <= 1'b1;
      t_powerup();
      t_standby();
      t_resume();
      t_abort();
      t_resume();
      tally_and_finish();
   end
endmodule
